/* File: hdl/ddr_param_pkg.sv */
`default_nettype none

package ddr_param_pkg;

  // ----------------------------------------
  // Bus geometry and own register offsets
  // ----------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] BYTE_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [11:0] TBL_FIRST = 12'h1d0;
  localparam logic [11:0] TBL_LAST = 12'h1e1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields and reset values
  localparam int CTRL_PTR_LSB = 0;
  localparam int CTRL_PTR_W = 12;
  localparam int CTRL_AUTO_BIT = 16;
  localparam logic [11:0] PTR_RST = 12'h1d0;

  // ----------------------------------------
  // Descriptor fields
  // ----------------------------------------
  localparam logic [7:0] OP_WR_ANY_REG = 8'h71;
  localparam logic [7:0] OP_RD_ANY_REG = 8'h65;
  localparam logic [23:0] DRV_VOL_ADDR = 24'h800005;
  localparam logic [7:0] DRV_NV_ADDR = 8'h05;
  localparam logic [1:0] DRV_FLD_WIDTH = 2'h3;   // 11b: three bits
  localparam logic [2:0] DRV_FLD_LSB = 3'h5;     // 101b: bit 5
  localparam logic [7:0] DRV_DESC_TOP = {DRV_FLD_WIDTH, 1'b0, 1'b1, 1'b0, DRV_FLD_LSB};
  localparam logic [2:0] DRV_PAT0 = 3'h0;        // 45 ohm
  localparam logic [2:0] DRV_PAT1 = 3'h5;        // 30 ohm
  localparam logic [2:0] DRV_PAT2 = 3'h3;        // 60 ohm
  localparam logic [2:0] DRV_PAT3 = 3'h2;        // 90 ohm
  localparam logic [2:0] DRV_PAT4 = 3'h0;        // Not supported
  localparam logic [15:0] DRV_ENC_HI = {DRV_PAT0, DRV_PAT1, DRV_PAT2, DRV_PAT3, DRV_PAT4, 1'b0};
  localparam logic [7:0] SEQ1_LEN = 8'h01;
  localparam logic [7:0] SEQ1_OP = 8'h06;
  localparam logic [7:0] SEQ2_LEN = 8'h05;       // Next table slice, kept for reference
  localparam logic [7:0] SEQ2_OP = 8'h71;        // Not issued; table bytes 1E0h and 1E1h read as zero
  localparam logic [7:0] SLOT_ZERO = 8'h00;

endpackage

`default_nettype wire

/* File: hdl/ddr_param_byte_rom.sv */
`default_nettype none

module ddr_param_byte_rom
  import ddr_param_pkg::*;
(
  input wire logic [ADDR_W-1:0] byte_addr,
  output logic [7:0] byte_data,
  output logic byte_hit
);

  // ----------------------------------------
  // Constant lookup, no state and no write path
  // ----------------------------------------
  function automatic logic [7:0] table_byte(input logic [ADDR_W-1:0] a);
    logic [7:0] v;
    v = SLOT_ZERO;
    unique case (a)
      12'h1d0: v = OP_WR_ANY_REG;
      12'h1d1: v = OP_RD_ANY_REG;
      12'h1d2: v = DRV_VOL_ADDR[7:0];
      12'h1d3: v = DRV_DESC_TOP;
      12'h1d4: v = OP_WR_ANY_REG;
      12'h1d5: v = OP_RD_ANY_REG;
      12'h1d6: v = DRV_NV_ADDR;
      12'h1d7: v = DRV_DESC_TOP;
      12'h1d8: v = SLOT_ZERO;
      12'h1d9: v = SLOT_ZERO;
      12'h1da: v = DRV_ENC_HI[7:0];
      12'h1db: v = DRV_ENC_HI[15:8];
      12'h1de: v = SEQ1_OP;
      12'h1df: v = SEQ1_LEN;
      default: v = SLOT_ZERO;                  // 1DCh, 1DDh, 1E0h, 1E1h
    endcase
    return v;
  endfunction

  assign byte_data = table_byte(byte_addr);
  assign byte_hit = (byte_addr >= TBL_FIRST) && (byte_addr <= TBL_LAST);

endmodule

`default_nettype wire

/* File: hdl/axil_write_join.sv */
`default_nettype none

module axil_write_join
  import ddr_param_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  output logic commit,
  output logic [ADDR_W-1:0] commit_addr,
  output logic [31:0] commit_data,
  output logic [3:0] commit_strb,
  input wire logic commit_err
);

  logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
  logic awready_q, wready_q;
  logic [1:0] bresp_q;
  logic [ADDR_W-1:0] addr_q;
  logic [31:0] data_q;
  logic [3:0] strb_q;
  wire aw_fire = awvalid & awready_q;
  wire w_fire = wvalid & wready_q;

  // ----------------------------------------
  // Address and data taken in either order, applied once both are held
  // ----------------------------------------
  assign commit = aw_held_q & w_held_q & ~bvalid_q;
  assign aw_held_d = (aw_held_q | aw_fire) & ~commit;
  assign w_held_d = (w_held_q | w_fire) & ~commit;
  assign bvalid_d = commit | (bvalid_q & ~bready);

  // Ready holds low while a response is pending so one write at a time is in flight
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      bvalid_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else
    begin
      aw_held_q <= aw_held_d;
      w_held_q <= w_held_d;
      bvalid_q <= bvalid_d;
      awready_q <= ~aw_held_d & ~bvalid_d & ~commit;
      wready_q <= ~w_held_d & ~bvalid_d & ~commit;
      if (commit)
        bresp_q <= commit_err ? RESP_SLVERR : RESP_OKAY;
    end
  end

  // Payload capture
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      addr_q <= '0;
      data_q <= '0;
      strb_q <= '0;
    end
    else
    begin
      if (aw_fire)
        addr_q <= awaddr;
      if (w_fire)
      begin
        data_q <= wdata;
        strb_q <= wstrb;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign commit_addr = addr_q;
  assign commit_data = data_q;
  assign commit_strb = strb_q;

endmodule

`default_nettype wire

/* File: hdl/sfdp_drive_ddr_param_rom.sv */
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`default_nettype none

module sfdp_drive_ddr_param_rom
  import ddr_param_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);

  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic wr_commit;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  wire [ADDR_W-1:0] wr_word = {wr_addr[ADDR_W-1:2], 2'b00};
  wire wr_ctrl = (wr_word == CTRL_OFS);
  wire wr_byte = (wr_word == BYTE_OFS);
  wire wr_stat = (wr_word == STAT_OFS);
  wire wr_table = (wr_word >= TBL_FIRST) && (wr_word <= {TBL_LAST[ADDR_W-1:2], 2'b00});
  // Table and byte-window writes accept the beat with OKAY but keep their value; a status write clears the counters
  wire wr_err = ~(wr_ctrl | wr_byte | wr_stat | wr_table);

  axil_write_join u_wjoin (
    .mclk(mclk),
    .resetn(resetn),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .awaddr(s_axi_awaddr),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .bresp(s_axi_bresp),
    .commit(wr_commit),
    .commit_addr(wr_addr),
    .commit_data(wr_data),
    .commit_strb(wr_strb),
    .commit_err(wr_err)
  );

  // ----------------------------------------
  // Read channel decode
  // ----------------------------------------
  logic arready_q, rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire ar_fire = s_axi_arvalid & arready_q;
  wire [ADDR_W-1:0] rd_word = {s_axi_araddr[ADDR_W-1:2], 2'b00};
  wire rd_ctrl = (rd_word == CTRL_OFS);
  wire rd_byte = (rd_word == BYTE_OFS);
  wire rd_stat = (rd_word == STAT_OFS);
  wire rd_valid_d = ar_fire | (rvalid_q & ~s_axi_rready);

  // Four lanes of the table word, lowest address in the low byte
  logic [31:0] tbl_word;
  logic [3:0] tbl_hit;
  genvar lane;
  generate
    for (lane = 0; lane < 4; lane++)
    begin : g_lane
      ddr_param_byte_rom u_lane (
        .byte_addr({s_axi_araddr[ADDR_W-1:2], 2'(lane)}),
        .byte_data(tbl_word[lane*8 +: 8]),
        .byte_hit(tbl_hit[lane])
      );
    end
  endgenerate
  wire rd_table = tbl_hit[0];

  // ----------------------------------------
  // Byte window: pointer-driven single-byte view of the table
  // ----------------------------------------
  logic [CTRL_PTR_W-1:0] ptr_q;
  logic auto_q;
  logic [7:0] win_data;
  logic win_hit;

  ddr_param_byte_rom u_window (
    .byte_addr(ptr_q),
    .byte_data(win_data),
    .byte_hit(win_hit)
  );

  wire win_read = ar_fire & rd_byte;
  wire win_step = win_read & auto_q & win_hit;
  // Software write of the pointer is newer than a read stepping it, so it wins
  wire ptr_wr_lo = wr_commit & wr_ctrl & wr_strb[0];
  wire ptr_wr_hi = wr_commit & wr_ctrl & wr_strb[1];
  wire auto_wr = wr_commit & wr_ctrl & wr_strb[2];
  wire [CTRL_PTR_W-1:0] ptr_step = ptr_q + 12'h001;
  wire [CTRL_PTR_W-1:0] ptr_base = win_step ? ptr_step : ptr_q;
  wire [CTRL_PTR_W-1:0] ptr_d = {ptr_wr_hi ? wr_data[11:8] : ptr_base[11:8],
                                 ptr_wr_lo ? wr_data[7:0] : ptr_base[7:0]};

  // Pointer and auto-increment enable
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ptr_q <= PTR_RST;
      auto_q <= 1'b0;
    end
    else
    begin
      ptr_q <= ptr_d;
      if (auto_wr)
        auto_q <= wr_data[CTRL_AUTO_BIT];
    end
  end

  // ----------------------------------------
  // Activity counters
  // ----------------------------------------
  // Ignored table writes, table word reads and all byte-window reads; a write to status clears both,
  // and an event in the same cycle still counts as one
  logic [15:0] ign_cnt_q, rd_cnt_q;
  wire stat_clr = wr_commit & wr_stat;
  wire ign_evt = wr_commit & wr_table;             // Table keeps its value
  wire rd_evt = (ar_fire & rd_table) | win_read;
  wire [15:0] ign_base = stat_clr ? 16'h0000 : ign_cnt_q;
  wire [15:0] rd_base = stat_clr ? 16'h0000 : rd_cnt_q;

  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      ign_cnt_q <= 16'h0000;
      rd_cnt_q <= 16'h0000;
    end
    else
    begin
      ign_cnt_q <= ign_evt ? ign_base + 16'h0001 : ign_base;
      rd_cnt_q <= rd_evt ? rd_base + 16'h0001 : rd_base;
    end
  end

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  wire [31:0] ctrl_view = {15'h0000, auto_q, 4'h0, ptr_q};
  wire [31:0] byte_view = {23'h000000, ~win_hit, win_data};
  wire [31:0] stat_view = {rd_cnt_q, ign_cnt_q};
  wire rd_ok = rd_ctrl | rd_byte | rd_stat | rd_table;
  // Table words come back unchanged on every read
  wire [31:0] rd_mux = rd_table ? tbl_word :
                       rd_ctrl ? ctrl_view :
                       rd_byte ? byte_view :
                       rd_stat ? stat_view : 32'h00000000;

  // One read in flight; arready drops while data waits for rready
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= RESP_OKAY;
    end
    else
    begin
      arready_q <= ~rd_valid_d;
      rvalid_q <= rd_valid_d;
      if (ar_fire)
      begin
        rdata_q <= rd_mux;
        rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule

`default_nettype wire

/* File: bench/rom_checker_properties.sv */
`default_nettype none

module rom_checker
  import ddr_param_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Table words and handshake timing
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Address taken at this edge; data must follow one cycle on
  sequence rd_at(logic [11:0] a);
    s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
  endsequence
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  chk_word_drv_vol:
  assert property (rd_at(12'h1d0) |=> s_axi_rvalid && s_axi_rdata == 32'hd5056571) else $error("word 1d0 wrong");
  chk_word_drv_nv:
  assert property (rd_at(12'h1d4) |=> s_axi_rvalid && s_axi_rdata == 32'hd5056571) else $error("word 1d4 wrong");
  chk_word_enc:
  assert property (rd_at(12'h1d8) |=> s_axi_rvalid && s_axi_rdata == 32'h15a00000) else $error("word 1d8 wrong");
  chk_word_seq_one:
  assert property (rd_at(12'h1dc) |=> s_axi_rvalid && s_axi_rdata == 32'h01060000) else $error("word 1dc wrong");
  chk_word_seq_tail:
  assert property (rd_at(12'h1e0) |=> s_axi_rvalid && s_axi_rdata == 32'h0) else $error("word 1e0 wrong");
  chk_rd_stands:
  assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
  chk_wr_answer:
  assert property (wr_both |=> !s_axi_bvalid ##1 s_axi_bvalid) else $error("write answer late");
  chk_tbl_wr_ok:
  assert property (wr_both and s_axi_awaddr inside {[12'h1d0:12'h1e0]} |=> ##1 s_axi_bresp == RESP_OKAY)
    else $error("table write refused");
endmodule

bind sfdp_drive_ddr_param_rom rom_checker rom_checker_inst (.mclk, .resetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);

`default_nettype wire

/* File: bench/axil_host.sv */
`default_nettype none

module axil_host
  import ddr_param_pkg::*;
(
  input wire logic mclk,
  output var logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output var logic [ADDR_W-1:0] s_axi_awaddr,
  output var logic s_axi_wvalid,
  input wire logic s_axi_wready,
  output var logic [31:0] s_axi_wdata,
  output var logic [3:0] s_axi_wstrb,
  input wire logic s_axi_bvalid,
  output var logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  output var logic s_axi_arvalid,
  input wire logic s_axi_arready,
  output var logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_rvalid,
  output var logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  output var logic hung
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Host side of the register bus
  // ----------------------------------------
  // Idle bus at time zero so nothing is offered during reset
  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, hung} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
  end
  // Each channel dropped only at the edge that takes it
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge mclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 64) hung <= 1'b1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 64; n++)
    begin
      @(posedge mclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 64) hung <= 1'b1;
  endtask
endmodule

`default_nettype wire

/* File: bench/sfdp_drive_ddr_param_rom_test.sv */
`default_nettype none

module sfdp_drive_ddr_param_rom_test
  import ddr_param_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, resetn, hung;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, got;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] words [5] = '{32'hd5056571, 32'hd5056571, 32'h15a00000, 32'h01060000, 32'h0};
  int miscompares = 0;
  int tests_run = 0;
  int i;
  // ----------------------------------------
  // Block, host and clock
  // ----------------------------------------
  sfdp_drive_ddr_param_rom sfdp_drive_ddr_param_rom_inst (.mclk, .resetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp);
  axil_host axil_host_inst (.mclk, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .hung);
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (miscompares == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A stuck handshake ends the run as a failure
  always @(posedge hung)
  begin
    miscompares++;
    report_and_stop();
  end
  // Word view, write attempts, counters, unmapped place, byte walk
  initial
  begin
    resetn = 1'b0;
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    for (i = 0; i < 5; i++)
    begin
      axil_host_inst.rd(TBL_FIRST + 12'(4 * i), got, resp);
      check(got, words[i]);
      check(32'(resp), 32'(RESP_OKAY));
    end
    axil_host_inst.wr(STAT_OFS, 32'h0, 4'hf, resp);
    axil_host_inst.wr(12'h1d8, 32'hffffffff, 4'hf, resp);
    check(32'(resp), 32'(RESP_OKAY));
    axil_host_inst.rd(12'h1d8, got, resp);
    check(got, 32'h15a00000);
    axil_host_inst.rd(STAT_OFS, got, resp);
    check(got, 32'h00010001);
    axil_host_inst.rd(12'h100, got, resp);
    check({got[31:2], resp}, 32'(RESP_SLVERR));
    axil_host_inst.wr(12'h100, 32'h1, 4'hf, resp);
    check(32'(resp), 32'(RESP_SLVERR));
    // Auto-increment walk: byte k of a word lands in bits 8k+7:8k
    axil_host_inst.wr(CTRL_OFS, 32'h000101d0, 4'h7, resp);
    for (i = 0; i < 18; i++)
    begin
      axil_host_inst.rd(BYTE_OFS, got, resp);
      check(got, 32'(8'(words[i / 4] >> (8 * (i % 4)))));
    end
    axil_host_inst.rd(BYTE_OFS, got, resp);
    check(got, 32'h00000100);
    // One word read and nineteen window reads counted; pointer parked past the end
    axil_host_inst.rd(STAT_OFS, got, resp);
    check(got, 32'h00140001);
    axil_host_inst.rd(CTRL_OFS, got, resp);
    check(got, 32'h000101e2);
    // Lanes 0 and 1 move the pointer alone, so auto-increment stays set
    axil_host_inst.wr(CTRL_OFS, 32'h000001de, 4'h3, resp);
    axil_host_inst.rd(BYTE_OFS, got, resp);
    check(got, 32'h00000006);
    axil_host_inst.rd(CTRL_OFS, got, resp);
    check(got, 32'h000101df);
    // Auto-increment off: the same byte twice, and a write to the window is ignored
    axil_host_inst.wr(CTRL_OFS, 32'h000001d0, 4'h7, resp);
    axil_host_inst.wr(BYTE_OFS, 32'hffffffff, 4'hf, resp);
    check(32'(resp), 32'(RESP_OKAY));
    for (i = 0; i < 2; i++)
    begin
      axil_host_inst.rd(BYTE_OFS, got, resp);
      check(got, 32'h00000071);
    end
    report_and_stop();
  end
endmodule

`default_nettype wire
